//--- testbench/ioipp_far.sv
// Model of the cache banks and noncacheable unit beyond the port.
// Assumes slow_i stretches cache request returns and noncacheable grants to one in four cycles.
module ioipp_far
   import ioipp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire ioipp_beat_s l2_o [Q_NUM],
   input wire ioipp_beat_s ncu_o [Q_NUM],
   input wire logic [Q_NUM-1:0] ncu_req_o,
   output logic [Q_NUM-1:0] l2_req_ret_o,
   output logic [Q_NUM-1:0] l2_wr_ret_o,
   output logic [Q_NUM-1:0] ncu_gnt_o,
   output logic [Q_NUM-1:0] rdret_free_o,
   output logic [Q_NUM-1:0] int_free_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] tick_r = 2'h0;
   int rq [Q_NUM];
   int bt [Q_NUM];
   always @(posedge clock_i) begin
      tick_r <= tick_r + 2'h1;
      l2_req_ret_o <= '0;
      l2_wr_ret_o <= '0;
      ncu_gnt_o <= '0;
      rdret_free_o <= '0;
      int_free_o <= '0;
      for (int i = 0; i < Q_NUM; i++) begin
         if (rst_i) begin
            rq[i] = 0;
            bt[i] = 0;
         end else begin
            rq[i] += int'(l2_o[i].vld && l2_o[i].hdr);
            bt[i] += int'(l2_o[i].vld && !l2_o[i].hdr);
            if (bt[i] == 4) begin
               bt[i] = 0;
               l2_wr_ret_o[i] <= 1'b1;
            end
            if ((!slow_i || tick_r == 2'h0) && rq[i] > 0) begin
               rq[i]--;
               l2_req_ret_o[i] <= 1'b1;
            end
            if ((!slow_i || tick_r == 2'h0) && ncu_req_o[i] && !ncu_gnt_o[i])
               ncu_gnt_o[i] <= 1'b1;
            if (ncu_o[i].vld && ncu_o[i].hdr) begin
               rdret_free_o[i] <= ncu_o[i].data[127:124] == TYPE_RDRET;
               int_free_o[i] <= ncu_o[i].data[127:124] == TYPE_INT;
            end
         end
      end
   end
endmodule : ioipp_far

//--- testbench/ioipp_props.sv
// Checker for the inbound packet port, attached to ioipp_top by bind.
// Assumes one clock and a synchronous active high reset.
module ioipp_props
   import ioipp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire ioipp_link_s link_i [Q_NUM],
   input wire ioipp_beat_s l2_o [Q_NUM],
   input wire logic [Q_NUM-1:0] l2_req_ret_i,
   input wire logic l2_resp_room_i,
   input wire ioipp_beat_s ncu_o [Q_NUM],
   input wire logic [Q_NUM-1:0] ncu_req_o,
   input wire logic [Q_NUM-1:0] ncu_gnt_i,
   input wire ioipp_err_s err_o [Q_NUM],
   input wire logic tp_req_i,
   input wire logic [ADDR_W-1:0] tp_addr_i,
   input wire ioipp_beat_s tp_l2_o,
   input wire logic tp_busy_o,
   input wire logic tp_err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pay_r;
   logic [2:0] pay_nxt;
   logic [2:0] cr_r;
   logic [2:0] cr_nxt;
   logic take;
   logic l2_hdr;
   assign take = link_i[0].hdr_vld && pay_r == 3'h0;
   assign l2_hdr = l2_o[0].vld && l2_o[0].hdr;
   assign pay_nxt = take ? (!link_i[0].datareq ? 3'h0 : link_i[0].short_payload_in ? 3'h1 : 3'h4)
      : (pay_r != 3'h0 ? pay_r - 3'h1 : pay_r);
   assign cr_nxt = cr_r - 3'(l2_hdr) + 3'(l2_req_ret_i[0]);
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pay_r <= 3'h0;
         cr_r <= 3'h2;
      end else begin
         pay_r <= pay_nxt;
         cr_r <= cr_nxt;
      end
   end
   function automatic logic [3:0] par(input logic [DATA_W-1:0] d);
      return {^d[127:96], ^d[95:64], ^d[63:32], ^d[31:0]};
   endfunction : par
   default clocking dc @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_beat;
      pay_r != 3'h0;
   endsequence
   sequence s_grant;
      ncu_req_o[0] && ncu_gnt_i[0];
   endsequence
   sequence s_tp_take;
      tp_req_i && !tp_busy_o;
   endsequence
   chk_par_bad_flag: assert property (s_beat ##0 par(link_i[0].data) != link_i[0].parity
      |=> err_o[0].parity) else $error("parity error not flagged");
   chk_par_good_quiet: assert property (s_beat ##0 par(link_i[0].data) == link_i[0].parity
      |=> !err_o[0].parity) else $error("false parity error");
   chk_hdr_par_ignored: assert property (take |=> !err_o[0].parity)
      else $error("header parity not ignored");
   chk_gnt_then_hdr: assert property (s_grant |=> ncu_o[0].vld && ncu_o[0].hdr && !ncu_req_o[0])
      else $error("no header after grant");
   chk_req_held: assert property (ncu_req_o[0] && !ncu_gnt_i[0] |=> ncu_req_o[0])
      else $error("request dropped before grant");
   chk_l2_room_ok: assert property (l2_hdr |-> $past(l2_resp_room_i))
      else $error("cache request without response room");
   chk_l2_credit_ok: assert property (l2_hdr |-> cr_r != 3'h0)
      else $error("cache request without credit");
   chk_tp_misalign: assert property (s_tp_take ##0 tp_addr_i[2:0] != 3'h0
      |=> tp_err_o && !tp_l2_o.vld) else $error("misaligned test access not refused");
   chk_tp_aligned: assert property (s_tp_take ##0 tp_addr_i[2:0] == 3'h0
      |=> tp_l2_o.vld && tp_l2_o.hdr && tp_busy_o && !tp_err_o) else $error("test access lost");
   chk_tp_crit_bit: assert property (
      tp_l2_o.vld && tp_l2_o.hdr && tp_l2_o.data[127:124] == TYPE_RDD
      |-> !tp_l2_o.data[TP_CRIT_BIT]) else $error("test read address bit two set");
endmodule : ioipp_props

bind ioipp_top ioipp_props ioipp_props_inst (.clock_i, .rst_i, .link_i, .l2_o, .l2_req_ret_i,
   .l2_resp_room_i, .ncu_o, .ncu_req_o, .ncu_gnt_i, .err_o, .tp_req_i, .tp_addr_i, .tp_l2_o,
   .tp_busy_o, .tp_err_o);

//--- testbench/tb_top.sv
// Self-checking bench for the inbound packet port with both links and the test port.
// Assumes the far side model answers every cache and noncacheable request.
module tb_top
   import ioipp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic slow = 1'b0;
   logic l2_resp_room_i = 1'b1;
   ioipp_link_s link_i [Q_NUM];
   ioipp_beat_s l2_o [Q_NUM];
   ioipp_beat_s ncu_o [Q_NUM];
   ioipp_err_s err_o [Q_NUM];
   logic [Q_NUM-1:0] l2_req_ret_i, l2_wr_ret_i, ncu_req_o, ncu_gnt_i;
   logic [Q_NUM-1:0] ncu_rdret_free_i, ncu_int_free_i, oq_dq_o, bq_dq_o;
   logic tp_req_i = 1'b0;
   logic tp_wr_i = 1'b0;
   logic tp_done_i = 1'b0;
   logic tp_busy_o, tp_err_o;
   logic [ADDR_W-1:0] tp_addr_i = '0;
   logic [TP_DATA_W-1:0] tp_wdata_i = '0;
   ioipp_beat_s tp_l2_o;
   ioipp_beat_s exp_q [3][$];
   logic [DATA_W-1:0] msk_q [3][$];
   int error_cnt = 0;
   int checks = 0;
   int seed = 2368;
   int dq_n [2] = '{0, 0};
   int dq_exp [2] = '{0, 0};
   int perr = 0;
   int ovf = 0;
   int tperr = 0;
   int tperr_exp = 0;
   int bad = 0;
   ioipp_type_t ty [6] = '{TYPE_RDRET, TYPE_RDD, TYPE_INT, TYPE_WRI, TYPE_WRI_NP, TYPE_WRM};
   int nb [6] = '{1, 0, 1, 4, 4, 4};

   ioipp_top ioipp_top_inst (.clock_i, .rst_i, .link_i, .l2_o, .l2_req_ret_i, .l2_wr_ret_i,
      .l2_resp_room_i, .ncu_o, .ncu_req_o, .ncu_gnt_i, .ncu_rdret_free_i, .ncu_int_free_i,
      .oq_dq_o, .bq_dq_o, .err_o, .tp_req_i, .tp_wr_i, .tp_addr_i, .tp_wdata_i, .tp_done_i,
      .tp_l2_o, .tp_busy_o, .tp_err_o);
   ioipp_far ioipp_far_inst (.clock_i, .rst_i, .slow_i(slow), .l2_o, .ncu_o, .ncu_req_o,
      .l2_req_ret_o(l2_req_ret_i), .l2_wr_ret_o(l2_wr_ret_i), .ncu_gnt_o(ncu_gnt_i),
      .rdret_free_o(ncu_rdret_free_i), .int_free_o(ncu_int_free_i));

   always #10 clock_i = ~clock_i;

   function automatic logic [3:0] par(input logic [DATA_W-1:0] d);
      return {^d[127:96], ^d[95:64], ^d[63:32], ^d[31:0]};
   endfunction : par

   task automatic check(input logic [144:0] seen, input logic [144:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic expect_beat(input int k, input ioipp_beat_s b, input logic [DATA_W-1:0] m);
      exp_q[k].push_back(b);
      msk_q[k].push_back(m);
   endtask : expect_beat

   task automatic got(input int k, input ioipp_beat_s b);
      ioipp_beat_s e;
      logic [DATA_W-1:0] m;
      if (exp_q[k].size() == 0) begin
         check(145'h1, 145'h0);
      end else begin
         e = exp_q[k].pop_front();
         m = msk_q[k].pop_front();
         check({b.hdr, b.data & m, b.hdr ? 16'h0 : b.be}, {e.hdr, e.data & m, e.be});
      end
   endtask : got

   always @(posedge clock_i) begin
      if (!rst_i) begin
         for (int i = 0; i < Q_NUM; i++) begin
            if (l2_o[i].vld) got(i, l2_o[i]);
            if (ncu_o[i].vld) got(i, ncu_o[i]);
            dq_n[i] += int'(oq_dq_o[i]) + int'(bq_dq_o[i]);
            perr += int'(err_o[i].parity);
            ovf += int'(err_o[i].overflow);
            bad += int'(err_o[i].bad_type);
         end
         if (tp_l2_o.vld) got(2, tp_l2_o);
         tperr += int'(tp_err_o);
      end
   end

   task automatic send(input int p, input logic byp, input ioipp_type_t t, input int n,
      input int bad, input logic keep);
      logic [DATA_W-1:0] d;
      logic [BE_W-1:0] be;
      d = {t, n == 1, 91'h0, 32'($random(seed))};
      link_i[p] <= {1'b1, byp, n != 0, n == 1, d, ~par(d), 16'($random(seed))};
      if (keep) expect_beat(p, {2'h3, d, 16'h0}, {4'hf, 124'h0});
      dq_exp[p] += int'(keep);
      @(posedge clock_i);
      for (int b = 0; b < n; b++) begin
         d = {$random(seed), $random(seed), $random(seed), $random(seed)};
         be = 16'($random(seed));
         link_i[p] <= {1'b0, ~byp, 2'h2, d, par(d) ^ {3'h0, b == bad}, be};
         if (keep) expect_beat(p, {2'h2, d, be}, '1);
         @(posedge clock_i);
      end
   endtask : send

   task automatic tp_access(input logic wr, input logic [ADDR_W-1:0] a);
      logic [TP_DATA_W-1:0] w;
      w = {$random(seed), $random(seed)};
      tp_req_i <= 1'b1;
      tp_wr_i <= wr;
      tp_addr_i <= a;
      tp_wdata_i <= w;
      if (a[2:0] == TP_ALIGN_ZERO) begin
         expect_beat(2, {2'h3, wr ? TYPE_WRM : TYPE_RDD, 84'h0, a & ~40'h4, 16'h0},
            {4'hf, 84'h0, {40{1'b1}}});
         if (wr) expect_beat(2, {2'h2, 64'h0, w, TP_WR_BE}, {64'h0, {64{1'b1}}});
      end else begin
         tperr_exp++;
      end
      @(posedge clock_i);
      tp_req_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      tp_done_i <= a[2:0] == TP_ALIGN_ZERO;
      @(posedge clock_i);
      tp_done_i <= 1'b0;
   endtask : tp_access

   task automatic finish_test(input string s);
      for (int c = 0; c < 3000 && exp_q[0].size() + exp_q[1].size() + exp_q[2].size() != 0; c++)
         @(posedge clock_i);
      repeat (8) @(posedge clock_i);
      $display("test %s done", s);
   endtask : finish_test

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      wrap_up();
   end

   initial begin
      for (int i = 0; i < Q_NUM; i++)
         link_i[i] = '0;
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      for (int p = 0; p < Q_NUM; p++) begin
         slow <= 1'(p);
         for (int k = 0; k < 6; k++)
            send(p, 1'(p), ty[k], nb[k], k == 5 ? 2 : -1, 1'b1);
         link_i[p].hdr_vld <= 1'b0;
         finish_test("stream");
      end
      send(0, 1'b0, 4'h7, 0, -1, 1'b0);
      dq_exp[0]++;
      link_i[0].hdr_vld <= 1'b0;
      finish_test("bad type");
      l2_resp_room_i <= 1'b0;
      for (int k = 0; k < 17; k++)
         send(1, 1'b0, TYPE_RDD, 0, -1, k < 16);
      link_i[1].hdr_vld <= 1'b0;
      repeat (10) @(posedge clock_i);
      check(145'(ovf), 145'h1);
      check(145'(exp_q[1].size()), 145'h10);
      l2_resp_room_i <= 1'b1;
      finish_test("overflow");
      tp_access(1'b1, 40'h12_3456_7890);
      tp_access(1'b0, 40'h00_0000_1238);
      tp_access(1'b0, 40'h00_0000_1234);
      finish_test("test port");
      check(145'(dq_n[0]), 145'(dq_exp[0]));
      check(145'(dq_n[1]), 145'(dq_exp[1]));
      check(145'(perr), 145'h2);
      check(145'(bad), 145'h1);
      check(145'(tperr), 145'(tperr_exp));
      check(145'(exp_q[0].size() + exp_q[1].size() + exp_q[2].size()), 145'h0);
      wrap_up();
   end
endmodule : tb_top

//--- verilog/ioipp_pkg.sv
// Constants, codes and carriers for the inbound packet port.
// Assumes one clock, the IO clock, shared by the link, cache and test sides.
package ioipp_pkg;
   localparam int DATA_W = 128;
   localparam int PAR_W = 4;
   localparam int BE_W = 16;
   localparam int LANE_W = 32;
   localparam int Q_DEPTH = 16;
   localparam int Q_NUM = 2;
   localparam int Q_ORD = 0;
   localparam int Q_BYP = 1;
   localparam int BEATS_LONG = 4;
   localparam int BEATS_SHORT = 1;
   localparam int L2_REQ_CREDITS = 2;
   localparam int L2_WR_CREDITS = 4;
   localparam int NCU_RDRET_MAX = 16;
   localparam int NCU_INT_MAX = 4;
   localparam int TYPE_HI = 127;
   localparam int TYPE_LO = 124;
   localparam int ADDR_W = 40;
   localparam int TP_DATA_W = 64;
   localparam int TP_CRIT_BIT = 2;
   localparam int CLK_RATIO = 4;
   localparam logic [2:0] TP_ALIGN_ZERO = 3'h0;
   localparam logic [15:0] TP_WR_BE = 16'h00ff;
   localparam logic [15:0] BE_ALL = 16'hffff;
   typedef logic [3:0] ioipp_type_t;
   localparam ioipp_type_t TYPE_RDRET = 4'h1;
   localparam ioipp_type_t TYPE_RDD = 4'h2;
   localparam ioipp_type_t TYPE_INT = 4'h3;
   localparam ioipp_type_t TYPE_WRI = 4'h4;
   localparam ioipp_type_t TYPE_WRI_NP = 4'h5;
   localparam ioipp_type_t TYPE_WRM = 4'h6;
   typedef struct packed {
      logic hdr_vld;
      logic bypass;
      logic datareq;
      logic short_payload_in;
      logic [DATA_W-1:0] data;
      logic [PAR_W-1:0] parity;
      logic [BE_W-1:0] byte_enables_in;
   } ioipp_link_s;
   typedef struct packed {
      logic vld;
      logic hdr;
      logic [DATA_W-1:0] data;
      logic [BE_W-1:0] be;
   } ioipp_beat_s;
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [BE_W-1:0] be;
   } ioipp_pay_s;
   typedef struct packed {
      logic parity;
      logic overflow;
      logic bad_type;
   } ioipp_err_s;
endpackage : ioipp_pkg

//--- verilog/ioipp_top.sv
// Inbound packet port of the system interface unit: two link receivers and a test port.
// Assumes clock_i is the IO clock, a synchronous quarter of the core clock.
// What this block does
// - A one-cycle header-valid marks the header; the receiver captures it then.
// - Queue-select high in the header cycle picks bypass, low picks ordered.
// - Payload-request low in the header cycle means a header-only packet.
// - Short-payload high gives one payload beat, otherwise four beats follow.
// - Parity bit N is the XOR of 32-bit data lane N.
// - Byte-enable bit N marks data byte N as written.
// - Moving a packet onward returns one credit for its queue.
// - Each subsystem gets two queues of 16 packets with 64-byte payloads.
// - Packets may follow back to back with no idle cycle.
// - Read returns, DMA reads, interrupts, full-line and merge writes are handled.
// - The receiver is built twice, one per IO subsystem.
// - Test-port accesses are 8-byte reads or writes with aligned addresses.
// - Test-port reads to a cache bank force address bit 2 to zero.
// - Cache traffic starts with two request and four write-data credits.
// - No cache request from a link receiver is sent without room for its response.
// - Grant pulses once; the packet follows next cycle; request holds until grant.
// - Up to 16 read returns and four interrupt payloads go to the noncacheable unit.
// - Core and IO clocks keep 4:1; the link side runs on the IO clock.
// - Parity and byte enables are ignored in the header cycle.

module ioipp_port
   import ioipp_pkg::*;
#(
   parameter int QD = Q_DEPTH,
   parameter int REQ_CR = L2_REQ_CREDITS,
   parameter int WR_CR = L2_WR_CREDITS
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire ioipp_link_s link_i,
   output ioipp_beat_s l2_o,
   input wire logic l2_req_ret_i,
   input wire logic l2_wr_ret_i,
   input wire logic l2_resp_room_i,
   output ioipp_beat_s ncu_o,
   output logic ncu_req_o,
   input wire logic ncu_gnt_i,
   input wire logic ncu_rdret_free_i,
   input wire logic ncu_int_free_i,
   output logic oq_dq_o,
   output logic bq_dq_o,
   output ioipp_err_s err_o
);
   localparam int PW = $clog2(QD);
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PAY} ioipp_st_e;

   function automatic logic [PAR_W-1:0] lane_par(input logic [DATA_W-1:0] d);
      logic [PAR_W-1:0] p;
      p = '0;
      for (int n = 0; n < PAR_W; n++) begin
         p[n] = ^d[n*LANE_W +: LANE_W];
      end
      return p;
   endfunction : lane_par

   function automatic logic type_to_l2(input ioipp_type_t t);
      return (t == TYPE_RDD) || (t == TYPE_WRI) || (t == TYPE_WRI_NP) || (t == TYPE_WRM);
   endfunction : type_to_l2

   logic [DATA_W-1:0] hdr_mem [Q_NUM][QD];
   ioipp_pay_s pay_mem [Q_NUM][QD][BEATS_LONG];
   logic [PW:0] cnt_r [Q_NUM];
   logic [PW:0] cnt_nxt [Q_NUM];
   logic [PW-1:0] wp_r [Q_NUM];
   logic [PW-1:0] rp_r [Q_NUM];
   logic [Q_NUM-1:0] push;
   logic [Q_NUM-1:0] pop;

   logic rx_busy_r;
   logic rx_q_r;
   logic rx_drop_r;
   logic [2:0] rx_left_r;
   logic [1:0] rx_beat_r;

   ioipp_st_e st_r;
   ioipp_st_e st_nxt;
   logic tx_q_r;
   logic tx_l2_r;
   logic [2:0] tx_beats_r;
   logic [1:0] tx_beat_r;
   ioipp_type_t tx_type_r;
   logic [2:0] req_cr_r;
   logic [2:0] wr_cr_r;
   logic [4:0] rdret_cnt_r;
   logic [2:0] int_cnt_r;
   logic ncu_req_r;
   ioipp_beat_s beat_nxt;
   ioipp_beat_s l2_r;
   ioipp_beat_s ncu_r;
   logic oq_dq_r;
   logic bq_dq_r;
   ioipp_err_s err_r;

   // Receive side: header capture and queue steering.
   wire hdr_fire = link_i.hdr_vld && !rx_busy_r;
   wire in_q = link_i.bypass;
   wire [2:0] hdr_beats = !link_i.datareq ? 3'd0 :
      (link_i.short_payload_in ? 3'(BEATS_SHORT) : 3'(BEATS_LONG));
   wire q_full = cnt_r[in_q] == (PW+1)'(QD);
   wire pay_fire = rx_busy_r;
   wire par_bad = pay_fire && (lane_par(link_i.data) != link_i.parity);
   wire rx_commit_hdr = hdr_fire && !q_full && (hdr_beats == 3'd0);
   wire rx_commit_pay = pay_fire && !rx_drop_r && (rx_left_r == 3'd1);

   always_comb begin
      for (int q = 0; q < Q_NUM; q++) begin
         push[q] = (rx_commit_hdr && in_q == q[0]) || (rx_commit_pay && rx_q_r == q[0]);
      end
   end

   always_ff @(posedge clock_i) begin
      if (hdr_fire && !q_full) begin
         hdr_mem[in_q][wp_r[in_q]] <= link_i.data;
      end
      if (pay_fire && !rx_drop_r) begin
         pay_mem[rx_q_r][wp_r[rx_q_r]][rx_beat_r] <= '{link_i.data, link_i.byte_enables_in};
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rx_busy_r <= 1'b0;
         rx_q_r <= 1'b0;
         rx_drop_r <= 1'b0;
         rx_left_r <= 3'd0;
         rx_beat_r <= 2'd0;
      end else if (hdr_fire) begin
         rx_busy_r <= hdr_beats != 3'd0;
         rx_q_r <= in_q;
         rx_drop_r <= q_full;
         rx_left_r <= hdr_beats;
         rx_beat_r <= 2'd0;
      end else if (pay_fire) begin
         rx_busy_r <= rx_left_r != 3'd1;
         rx_left_r <= rx_left_r - 3'd1;
         rx_beat_r <= rx_beat_r + 2'd1;
      end
   end

   // Transmit side: bypass queue first, then ordered queue.
   wire byp_has = cnt_r[Q_BYP] != '0;
   wire ord_has = cnt_r[Q_ORD] != '0;
   wire sel_q = byp_has;
   wire [DATA_W-1:0] sel_hdr = hdr_mem[sel_q][rp_r[sel_q]];
   wire ioipp_type_t sel_type = sel_hdr[TYPE_HI:TYPE_LO];
   wire sel_l2 = type_to_l2(sel_type);
   wire sel_ok = sel_l2 || sel_type == TYPE_RDRET || sel_type == TYPE_INT;
   wire start = st_r == ST_IDLE && (byp_has || ord_has);
   wire bad_drop = start && !sel_ok;
   wire is_wr = tx_beats_r != 3'd0;
   wire l2_go = st_r == ST_WAIT && tx_l2_r && req_cr_r != '0 && l2_resp_room_i &&
      (!is_wr || wr_cr_r != '0);
   wire ncu_room = (tx_type_r == TYPE_RDRET) ? (rdret_cnt_r < 5'(NCU_RDRET_MAX)) :
      (int_cnt_r < 3'(NCU_INT_MAX));
   wire ncu_go = st_r == ST_WAIT && !tx_l2_r && ncu_req_r && ncu_gnt_i;
   wire go = l2_go || ncu_go;
   wire pay_last = st_r == ST_PAY && tx_beat_r == 2'(tx_beats_r - 3'd1);
   wire tx_done = (go && !is_wr) || pay_last || bad_drop;
   wire [DATA_W-1:0] cur_hdr = hdr_mem[tx_q_r][rp_r[tx_q_r]];
   wire ioipp_pay_s cur_pay = pay_mem[tx_q_r][rp_r[tx_q_r]][tx_beat_r];
   wire done_q = bad_drop ? sel_q : tx_q_r;

   always_comb begin
      for (int q = 0; q < Q_NUM; q++) begin
         pop[q] = tx_done && done_q == q[0];
         cnt_nxt[q] = cnt_r[q] + (PW+1)'(push[q]) - (PW+1)'(pop[q]);
      end
   end

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (start && sel_ok) begin
               st_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (go) begin
               st_nxt = is_wr ? ST_PAY : ST_IDLE;
            end
         end
         ST_PAY: begin
            if (pay_last) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_comb begin
      beat_nxt = '0;
      if (go) begin
         beat_nxt = '{1'b1, 1'b1, cur_hdr, BE_ALL};
      end else if (st_r == ST_PAY) begin
         beat_nxt = '{1'b1, 1'b0, cur_pay.data, cur_pay.be};
      end
   end

   wire ncu_req_nxt = st_r == ST_WAIT && !tx_l2_r && ncu_room && !ncu_go;
   wire ncu_take = ncu_go;
   wire rd_inc = ncu_take && tx_type_r == TYPE_RDRET;
   wire int_inc = ncu_take && tx_type_r == TYPE_INT;
   wire req_dec = l2_go;
   wire wr_dec = l2_go && is_wr;

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= ST_IDLE;
         tx_q_r <= 1'b0;
         tx_l2_r <= 1'b0;
         tx_beats_r <= 3'd0;
         tx_beat_r <= 2'd0;
         tx_type_r <= '0;
      end else begin
         st_r <= st_nxt;
         if (start) begin
            tx_q_r <= sel_q;
            tx_l2_r <= sel_l2;
            tx_type_r <= sel_type;
            tx_beats_r <= sel_hdr[TYPE_LO-1] ? 3'(BEATS_SHORT) :
               ((sel_type == TYPE_RDD || sel_type == TYPE_INT) ? 3'd0 : 3'(BEATS_LONG));
            tx_beat_r <= 2'd0;
         end else if (st_r == ST_PAY) begin
            tx_beat_r <= tx_beat_r + 2'd1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int q = 0; q < Q_NUM; q++) begin
            cnt_r[q] <= '0;
            wp_r[q] <= '0;
            rp_r[q] <= '0;
         end
      end else begin
         for (int q = 0; q < Q_NUM; q++) begin
            cnt_r[q] <= cnt_nxt[q];
            wp_r[q] <= wp_r[q] + PW'(push[q]);
            rp_r[q] <= rp_r[q] + PW'(pop[q]);
         end
      end
   end

   // Credit counters: a return in the same cycle as a use leaves the count unchanged.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         req_cr_r <= 3'(REQ_CR);
         wr_cr_r <= 3'(WR_CR);
         rdret_cnt_r <= '0;
         int_cnt_r <= '0;
      end else begin
         req_cr_r <= req_cr_r + 3'(l2_req_ret_i) - 3'(req_dec);
         wr_cr_r <= wr_cr_r + 3'(l2_wr_ret_i) - 3'(wr_dec);
         rdret_cnt_r <= rdret_cnt_r + 5'(rd_inc) - 5'(ncu_rdret_free_i);
         int_cnt_r <= int_cnt_r + 3'(int_inc) - 3'(ncu_int_free_i);
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         l2_r <= '0;
         ncu_r <= '0;
         ncu_req_r <= 1'b0;
         oq_dq_r <= 1'b0;
         bq_dq_r <= 1'b0;
         err_r <= '0;
      end else begin
         l2_r <= tx_l2_r ? beat_nxt : '0;
         ncu_r <= tx_l2_r ? '0 : beat_nxt;
         ncu_req_r <= ncu_req_nxt;
         oq_dq_r <= pop[Q_ORD];
         bq_dq_r <= pop[Q_BYP];
         err_r <= '{par_bad, hdr_fire && q_full, bad_drop};
      end
   end

   assign l2_o = l2_r;
   assign ncu_o = ncu_r;
   assign ncu_req_o = ncu_req_r;
   assign oq_dq_o = oq_dq_r;
   assign bq_dq_o = bq_dq_r;
   assign err_o = err_r;
endmodule : ioipp_port

module ioipp_top
   import ioipp_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire ioipp_link_s link_i [Q_NUM],
   output ioipp_beat_s l2_o [Q_NUM],
   input wire logic [Q_NUM-1:0] l2_req_ret_i,
   input wire logic [Q_NUM-1:0] l2_wr_ret_i,
   input wire logic l2_resp_room_i,
   output ioipp_beat_s ncu_o [Q_NUM],
   output logic [Q_NUM-1:0] ncu_req_o,
   input wire logic [Q_NUM-1:0] ncu_gnt_i,
   input wire logic [Q_NUM-1:0] ncu_rdret_free_i,
   input wire logic [Q_NUM-1:0] ncu_int_free_i,
   output logic [Q_NUM-1:0] oq_dq_o,
   output logic [Q_NUM-1:0] bq_dq_o,
   output ioipp_err_s err_o [Q_NUM],
   input wire logic tp_req_i,
   input wire logic tp_wr_i,
   input wire logic [ADDR_W-1:0] tp_addr_i,
   input wire logic [TP_DATA_W-1:0] tp_wdata_i,
   input wire logic tp_done_i,
   output ioipp_beat_s tp_l2_o,
   output logic tp_busy_o,
   output logic tp_err_o
);
   for (genvar i = 0; i < Q_NUM; i++) begin : g_port
      ioipp_port u_port (
         .clock_i(clock_i),
         .rst_i(rst_i),
         .link_i(link_i[i]),
         .l2_o(l2_o[i]),
         .l2_req_ret_i(l2_req_ret_i[i]),
         .l2_wr_ret_i(l2_wr_ret_i[i]),
         .l2_resp_room_i(l2_resp_room_i),
         .ncu_o(ncu_o[i]),
         .ncu_req_o(ncu_req_o[i]),
         .ncu_gnt_i(ncu_gnt_i[i]),
         .ncu_rdret_free_i(ncu_rdret_free_i[i]),
         .ncu_int_free_i(ncu_int_free_i[i]),
         .oq_dq_o(oq_dq_o[i]),
         .bq_dq_o(bq_dq_o[i]),
         .err_o(err_o[i])
      );
   end

   // Test port: one access at a time, eight bytes, aligned address.
   logic tp_busy_r;
   logic tp_data_r;
   logic [TP_DATA_W-1:0] tp_wdata_r;
   ioipp_beat_s tp_out_r;
   ioipp_beat_s tp_hdr;
   logic tp_err_r;

   wire tp_take = tp_req_i && !tp_busy_r;
   wire tp_aligned = tp_addr_i[2:0] == TP_ALIGN_ZERO;
   wire tp_accept = tp_take && tp_aligned;
   wire [ADDR_W-1:0] tp_addr_fwd = tp_wr_i ? tp_addr_i :
      (tp_addr_i & ~(ADDR_W'(1) << TP_CRIT_BIT));
   wire ioipp_type_t tp_type = tp_wr_i ? TYPE_WRM : TYPE_RDD;

   always_comb begin
      tp_hdr = '0;
      tp_hdr.vld = 1'b1;
      tp_hdr.hdr = 1'b1;
      tp_hdr.data[TYPE_HI:TYPE_LO] = tp_type;
      tp_hdr.data[TYPE_LO-1] = tp_wr_i;
      tp_hdr.data[ADDR_W-1:0] = tp_addr_fwd;
      tp_hdr.be = BE_ALL;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         tp_busy_r <= 1'b0;
         tp_data_r <= 1'b0;
         tp_wdata_r <= '0;
         tp_out_r <= '0;
         tp_err_r <= 1'b0;
      end else begin
         tp_err_r <= tp_take && !tp_aligned;
         tp_data_r <= tp_accept && tp_wr_i;
         if (tp_accept) begin
            tp_busy_r <= 1'b1;
            tp_wdata_r <= tp_wdata_i;
            tp_out_r <= tp_hdr;
         end else if (tp_data_r) begin
            tp_out_r <= '{1'b1, 1'b0, DATA_W'(tp_wdata_r), TP_WR_BE};
         end else begin
            tp_out_r <= '0;
            if (tp_done_i) begin
               tp_busy_r <= 1'b0;
            end
         end
      end
   end

   assign tp_l2_o = tp_out_r;
   assign tp_busy_o = tp_busy_r;
   assign tp_err_o = tp_err_r;
endmodule : ioipp_top
